// ### hdl/link_sync.sv
// two-flop synchronisers and edge detection for the serial link pins
`timescale 1ns/1ps
`default_nettype none
module link_sync
   import sar_seq_pkg::*;
(
   input wire logic ref_clk, // sampling clock
   input wire logic reset, // async, active high
   input wire logic clk_en, // freezes state while low
   input wire logic sel_n, // chip select pin, active low
   input wire logic sclk, // serial clock pin
   output link_ev_t ev // synchronised levels and edges
);
   typedef struct packed {
      logic [1:0] sel_meta;
      logic [1:0] clk_meta;
      logic sel_prev;
      logic clk_prev;
   } sync_state_t;

   sync_state_t st;
   sync_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.sel_meta = {st.sel_meta[0], sel_n};
      next_st.clk_meta = {st.clk_meta[0], sclk};
      next_st.sel_prev = st.sel_meta[1];
      next_st.clk_prev = st.clk_meta[1];
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         // reset levels match the parked-high pins, so release shows no false edge
         st <= '{sel_meta: 2'b11, clk_meta: 2'b11, sel_prev: 1'b1, clk_prev: 1'b1};
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   always_comb begin
      ev.sel_low = ~st.sel_meta[1];
      ev.clk_level = st.clk_meta[1];
      ev.sel_fall = st.sel_prev & ~st.sel_meta[1];
      ev.sel_rise = ~st.sel_prev & st.sel_meta[1];
      ev.clk_fall = st.clk_prev & ~st.clk_meta[1];
      ev.clk_rise = ~st.clk_prev & st.clk_meta[1];
   end
endmodule
`default_nettype wire

// ### hdl/sar_adc_serial_frame_sequencer.sv
// serial frame sequencer for a 12-bit differential sar converter
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_frame_sequencer
   import sar_seq_pkg::*;
#(
   parameter int WIDTH = RESULT_BITS // result width
) (
   input wire logic ref_clk, // 25 MHz block clock
   input wire logic reset, // async, active high
   input wire logic clk_en, // freezes state while low
   input wire logic sel_n, // chip select pin, active low
   input wire logic sclk, // serial clock pin from host
   input wire logic [WIDTH-1:0] sample_code, // comparator result of the analog array
   output logic dout_o, // serial output value
   output logic dout_oe, // serial output enable, high drives
   output logic array_track, // high while array follows the inputs
   output logic sample_take, // pulse: hold the input on the array
   output logic [1:0] phase // current phase
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      phase_t ph;
      logic [3:0] fall_cnt;
      logic [WIDTH-1:0] held;
      logic dout;
      logic oe;
      logic track;
      logic take;
      logic armed;
   } seq_state_t;

   seq_state_t st;
   seq_state_t next_st;
   link_ev_t ev;

   // pin edges reach the state three block clocks late, so each serial clock
   // half period must span at least three block clocks
   link_sync u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .sel_n(sel_n),
      .sclk(sclk),
      .ev(ev)
   );

   // msb-first bit for a given falling edge count after the leading zeros
   function automatic logic result_bit(input logic [WIDTH-1:0] code, input logic [3:0] cnt);
      logic [3:0] idx;
      idx = 4'(cnt - EDGE_CNT_FIRST_DATA);
      result_bit = code[WIDTH-1-int'(idx)];
   endfunction

   // ************************************************************
   // sequencing
   // ************************************************************
   always_comb begin
      next_st = st;
      next_st.take = 1'b0;
      if (!ev.sel_low) begin
         // select high: abort any conversion and float the output
         next_st.ph = ST_IDLE;
         next_st.oe = 1'b0;
         next_st.dout = 1'b0;
         next_st.fall_cnt = EDGE_CNT_RESET;
         next_st.track = 1'b1;
         next_st.armed = 1'b0;
      end else if (ev.sel_fall) begin
         next_st.oe = 1'b1;
         next_st.dout = 1'b0;
         next_st.fall_cnt = EDGE_CNT_RESET;
         if (!ev.clk_level || ev.clk_fall) begin
            // clock already low or falling together: this is fall one
            next_st.ph = ST_ACQ;
            next_st.fall_cnt = 4'h1;
            next_st.armed = 1'b1;
         end else begin
            next_st.ph = ST_IDLE;
            next_st.armed = 1'b1;
         end
      end else if (ev.clk_fall && st.armed) begin
         // while select stays low, dout changes only here, on a clock fall
         if (st.ph == ST_IDLE || st.fall_cnt == EDGE_CNT_RESET) begin
            next_st.ph = ST_ACQ;
            next_st.fall_cnt = 4'h1;
            next_st.track = 1'b1;
            next_st.dout = 1'b0;
         end else begin
            next_st.fall_cnt = 4'(st.fall_cnt + 4'h1); // wraps to zero at sixteen
            if (st.fall_cnt == EDGE_CNT_CONV_START) begin
               // fourth fall: hold input, isolate array, start converting
               next_st.ph = ST_CONV;
               next_st.held = sample_code;
               next_st.take = 1'b1;
               next_st.track = 1'b0;
               next_st.dout = 1'b0;
            end else if (st.fall_cnt >= EDGE_CNT_FIRST_DATA) begin
               next_st.dout = result_bit(st.held, st.fall_cnt);
            end else begin
               next_st.dout = 1'b0;
            end
            if (st.fall_cnt == EDGE_CNT_LAST) begin
               // sixteenth fall: lsb out, next fall starts a new acquisition
               next_st.fall_cnt = EDGE_CNT_RESET;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= '{ph: ST_IDLE, fall_cnt: EDGE_CNT_RESET, held: '0, dout: 1'b0,
                 oe: 1'b0, track: 1'b1, take: 1'b0, armed: 1'b0};
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   always_comb begin
      dout_o = st.dout;
      dout_oe = st.oe;
      array_track = st.track;
      sample_take = st.take;
      phase = st.ph;
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_float_when_high: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && !ev.sel_low) |=> !dout_oe)
      else $error("output driven while select high");
   chk_drive_after_fall: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_fall) |=> dout_oe)
      else $error("output not enabled after select fall");
   chk_zeros_lead: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_low && !ev.sel_fall && ev.clk_fall && st.armed
       && st.ph != ST_IDLE && st.fall_cnt inside {4'h1, 4'h2, 4'h3}) |=> !dout_o)
      else $error("leading zero not driven");
   chk_hold_at_four: assert property (@(posedge ref_clk) disable iff (reset)
      sample_take |-> (!array_track && phase == ST_CONV && st.fall_cnt == 4'h4))
      else $error("input held at wrong position");
   chk_out_stable: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_low && !ev.sel_fall && !ev.clk_fall) |=> $stable(dout_o))
      else $error("output changed without a clock fall");
   chk_isolate_conv: assert property (@(posedge ref_clk) disable iff (reset)
      (phase == ST_CONV) |-> !array_track)
      else $error("array tracking during conversion");
   chk_msb_first: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_low && !ev.sel_fall && ev.clk_fall && st.armed
       && st.ph == ST_CONV && st.fall_cnt == 4'h4) |=> dout_o == st.held[WIDTH-1])
      else $error("msb not first result bit");
   chk_wrap_reacq: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_low && !ev.sel_fall && ev.clk_fall && st.armed
       && st.ph == ST_CONV && st.fall_cnt == EDGE_CNT_RESET) |=> (phase == ST_ACQ))
      else $error("no reacquisition after sixteen cycles");
   chk_cs_low_acq: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_fall && !ev.clk_level) |=> (phase == ST_ACQ && st.fall_cnt == 4'h1))
      else $error("select fall with clock low not counted as fall one");

   // ************************************************************
   // phase and counter checks
   // ************************************************************
   chk_take_single: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && sample_take) |=> !sample_take)
      else $error("hold pulse longer than one cycle");
   chk_idle_on_rise: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && !ev.sel_low) |=> (phase == ST_IDLE && array_track))
      else $error("no abort while select high");
   chk_wait_first_fall: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_fall && ev.clk_level)
      |=> (phase == ST_IDLE && st.fall_cnt == EDGE_CNT_RESET && dout_oe))
      else $error("select fall with clock high did not wait for a clock fall");
   chk_first_fall_acq: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_low && !ev.sel_fall && ev.clk_fall && st.armed && st.ph == ST_IDLE)
      |=> (phase == ST_ACQ && st.fall_cnt == 4'h1))
      else $error("no acquisition at first clock fall");
   chk_joint_fall: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_fall && ev.clk_fall) |=> (phase == ST_ACQ && st.fall_cnt == 4'h1))
      else $error("joint select and clock fall not taken as acquisition");
   chk_conv_at_four: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_low && !ev.sel_fall && ev.clk_fall && st.armed
       && st.ph == ST_ACQ && st.fall_cnt == EDGE_CNT_CONV_START)
      |=> (phase == ST_CONV && sample_take && !array_track))
      else $error("conversion not started at fourth fall");
   chk_lsb_last: assert property (@(posedge ref_clk) disable iff (reset)
      (clk_en && ev.sel_low && !ev.sel_fall && ev.clk_fall && st.armed
       && st.ph == ST_CONV && st.fall_cnt == EDGE_CNT_LAST)
      |=> (dout_o == st.held[0] && st.fall_cnt == EDGE_CNT_RESET))
      else $error("lsb not on sixteenth fall");
   chk_acq_count: assert property (@(posedge ref_clk) disable iff (reset)
      (phase == ST_ACQ) |-> (st.fall_cnt inside {4'h1, 4'h2, 4'h3}))
      else $error("acquisition outside falls one to three");
   chk_conv_count: assert property (@(posedge ref_clk) disable iff (reset)
      (phase == ST_CONV)
      |-> (st.fall_cnt >= EDGE_CNT_FIRST_DATA || st.fall_cnt == EDGE_CNT_RESET))
      else $error("conversion outside falls four to sixteen");
   chk_held_conv: assert property (@(posedge ref_clk) disable iff (reset)
      (phase == ST_CONV && !sample_take) |-> $stable(st.held))
      else $error("held result changed during conversion");
   chk_oe_frame: assert property (@(posedge ref_clk) disable iff (reset)
      (phase != ST_IDLE) |-> dout_oe)
      else $error("output floating inside a frame");
endmodule
`default_nettype wire

// ### hdl/sar_seq_pkg.sv
// shared constants and carrier types for the serial frame sequencer
package sar_seq_pkg;
   localparam int RESULT_BITS = 12;
   localparam int CYCLES_PER_CONV = 16;
   localparam int LEAD_ZEROS = 4;
   localparam int ACQ_CYCLES = 3;
   localparam logic [3:0] EDGE_CNT_RESET = 4'h0;
   localparam logic [3:0] EDGE_CNT_LAST = 4'hF;
   localparam logic [3:0] EDGE_CNT_FIRST_DATA = 4'h4;
   localparam logic [3:0] EDGE_CNT_CONV_START = 4'h3;
   localparam logic [11:0] CODE_POS_FULL = 12'h7FF;
   localparam logic [11:0] CODE_NEG_FULL = 12'h800;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACQ = 2'b01,
      ST_CONV = 2'b10
   } phase_t;

   // synchronised link pins and their edge events
   typedef struct packed {
      logic sel_low;
      logic clk_level;
      logic sel_fall;
      logic sel_rise;
      logic clk_fall;
      logic clk_rise;
   } link_ev_t;
endpackage

// ### tb/host_master.sv
// host serial master model: drives select and clock, captures the data line
`timescale 1ns/1ps
`default_nettype none
module host_master (
   output logic sel_n, // chip select, active low
   output logic sclk, // serial clock, parked high between frames
   input wire logic dout // resolved serial data line
);
   initial begin
      sel_n = 1'b1;
      sclk = 1'b1;
   end
   // mode 0: select falls with clock high, 1: clock already low, 2: both fall together
   // each bit is taken on the rising clock edge, half a period after the fall that set it
   task automatic run_frame(input int nfalls, input int mode, output logic [31:0] bits);
      int first;
      bits = 32'h0000_0000;
      first = (mode == 0) ? 1 : 2;
      if (mode == 1) begin
         sclk = 1'b0;
         #320;
      end
      if (mode == 2) sclk = 1'b0;
      sel_n = 1'b0;
      if (mode == 0) #320;
      else begin
         // the select fall itself counts as fall one
         #160 sclk = 1'b1;
         bits = {bits[30:0], dout};
         #160;
      end
      for (int k = first; k <= nfalls; k++) begin
         sclk = 1'b0;
         #160 sclk = 1'b1;
         bits = {bits[30:0], dout};
         #160;
      end
      sel_n = 1'b1;
      #400;
   endtask
endmodule
`default_nettype wire

// ### tb/tb_sar_adc_serial_frame_sequencer.sv
// self-checking bench for the serial frame sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_sar_adc_serial_frame_sequencer;
   import sar_seq_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic [11:0] sample_code = 12'h000;
   logic dout_o, dout_oe, array_track, sample_take;
   logic [1:0] phase;
   logic last_v = 1'b0;
   logic [31:0] got;
   int failures = 0;
   int checks = 0;
   wire sel_n;
   wire sclk;
   // a released line must not show its last value
   wire dout_w = dout_oe ? dout_o : ~last_v;
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (dout_oe) last_v <= dout_o;
   host_master host (.sel_n(sel_n), .sclk(sclk), .dout(dout_w));
   sar_adc_serial_frame_sequencer uut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
      .sel_n(sel_n), .sclk(sclk), .sample_code(sample_code), .dout_o(dout_o),
      .dout_oe(dout_oe), .array_track(array_track), .sample_take(sample_take), .phase(phase));
   // ***************************************
   // shared tasks
   // ***************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      if (failures == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check_idle;
      check("dout_oe", 32'h0000_0000, {31'h0, dout_oe});
      check("phase", {30'h0, ST_IDLE}, {30'h0, phase});
      check("array_track", 32'h0000_0001, {31'h0, array_track});
   endtask
   // ***************************************
   // scenarios
   // ***************************************
   task automatic test_reset;
      repeat (4) @(posedge ref_clk);
      check_idle();
      check("sample_take", 32'h0000_0000, {31'h0, sample_take});
      repeat (4) @(posedge ref_clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic test_entry;
      logic [11:0] codes [3] = '{CODE_POS_FULL, CODE_NEG_FULL, 12'hA5C};
      for (int m = 0; m < 3; m++) begin
         @(posedge ref_clk) #1 sample_code = codes[m];
         host.run_frame(16, m, got);
         check("frame bits", {20'h0_0000, codes[m]}, got);
         check_idle();
      end
   endtask
   task automatic test_continuous;
      @(posedge ref_clk) #1 sample_code = 12'h3C6;
      fork
         host.run_frame(32, 0, got);
         begin
            @(posedge sample_take);
            @(negedge ref_clk);
            check("phase at hold", {30'h0, ST_CONV}, {30'h0, phase});
            check("array_track at hold", 32'h0000_0000, {31'h0, array_track});
            @(posedge ref_clk) #1 sample_code = 12'hC39;
            check("sample_take width", 32'h0000_0000, {31'h0, sample_take});
         end
      join
      check("back to back", 32'h03C6_0C39, got);
   endtask
   task automatic test_short;
      @(posedge ref_clk) #1 sample_code = 12'h9B4;
      host.run_frame(8, 0, got);
      check("short frame", 32'h0000_0009, got);
      check_idle();
      host.run_frame(16, 0, got);
      check("fresh frame", 32'h0000_09B4, got);
   endtask
   task automatic test_freeze;
      @(posedge ref_clk) #1 clk_en = 1'b0;
      fork
         host.run_frame(8, 0, got);
         begin
            repeat (40) @(posedge ref_clk);
            #1 check_idle();
         end
      join
      @(posedge ref_clk) #1 clk_en = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 check_idle();
   endtask
   task automatic test_mid_reset;
      @(posedge ref_clk) #1 sample_code = 12'h5A3;
      fork
         host.run_frame(16, 0, got);
         begin
            repeat (60) @(posedge ref_clk);
            #1 reset = 1'b1;
            @(posedge ref_clk) #1 check_idle();
            reset = 1'b0;
         end
      join
      check_idle();
      host.run_frame(16, 0, got);
      check("after reset", 32'h0000_05A3, got);
   endtask
   initial begin
      test_reset();
      test_entry();
      test_continuous();
      test_short();
      test_freeze();
      test_mid_reset();
      close_out();
   end
   // whole run takes about 53 us of frames
   initial begin
      #300000;
      failures = failures + 1;
      close_out();
   end
endmodule
`default_nettype wire
